// [ssfe_pkg.sv]
// Shared constants and types of the synchronous serial frame engine.
package ssfe_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int        WORD_W      = 16;
  localparam int        FIFO_DEPTH  = 16;
  localparam logic      FMT_SPI     = 1'b0;
  localparam logic      FMT_CMD     = 1'b1;
  localparam logic [6:0] CMD_BITS   = 7'd8;
  localparam logic [6:0] CMD_WAIT   = 7'd1;
  localparam logic [6:0] CMD_LAST_TX_EDGE = 7'd16;
  localparam logic [6:0] CMD_FIRST_RX_EDGE = 7'd19;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_PERIOD_NS = 160;
  localparam int HALF_CYCLES   = (BIT_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSFE_IDLE,
    SSFE_RUN,
    SSFE_GAP
  } ssfe_state_t;
endpackage : ssfe_pkg

// [ssfe_fifo.sv]
// Parameterised valid/ready FIFO that buffers transmit words.
`timescale 1ns/1ps
module ssfe_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  // DEPTH must be a power of two; the pointers wrap by overflow.
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } ssfe_fifo_t;

  ssfe_fifo_t st_reg;
  ssfe_fifo_t st_next;
  logic       push;
  logic       pop;

  assign in_ready  = st_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data  = st_reg.mem[st_reg.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp             = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : ssfe_fifo

// [ssfe_engine.sv]
// Frame-timing engine of a synchronous serial port, master and slave.
`timescale 1ns/1ps
// Operation
// - Idle: select high, output low, clock pad per role.
// - SPI idle clock level equals polarity.
// - Enabled master with queued word starts frame.
// - Phase 0: data half period, edge after.
// - Polarity 0 phase 0: sample rising, change falling.
// - Polarity 1 phase 0: sample falling, change rising.
// - Phase 0 bursts pulse select between words.
// - Select rises one bit after last sample.
// - Phase 1: first bit and edge after half.
// - Polarity 0 phase 1: sample falling, change rising.
// - Polarity 1 phase 1: sample rising, change falling.
// - Phase 1 bursts keep select low throughout.
// - Command byte, one wait, 4-16 bit reply.
// - Command frame loads word, drives MSB at select.
// - Reply bits latched on rising clock edges.
// - Single command frame ends one clock after.
// - Continuous command frames chain next byte directly.
// - Command slave samples first rising edge.
// - Words 4 to 16 bits, MSB first.
module ssfe_engine #(
  parameter int HALF = ssfe_pkg::HALF_CYCLES,
  parameter int W    = ssfe_pkg::WORD_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         enable,
  input  wire logic         is_master,
  input  wire logic         frame_format,
  input  wire logic         clock_idle_polarity,
  input  wire logic         clock_phase_select,
  input  wire logic [3:0]   data_bits_m1,
  input  wire logic [3:0]   reply_bits_m1,
  input  wire logic [W-1:0] tx_data,
  input  wire logic         tx_valid,
  output logic              tx_ready,
  output logic [W-1:0]      rx_data,
  output logic              rx_valid,
  output logic              busy,
  input  wire logic         serial_clock_pin_in,
  output logic              serial_clock_pin_out,
  output logic              serial_clock_pin_oe,
  input  wire logic         frame_select_pin_in,
  output logic              frame_select_pin_out,
  output logic              frame_select_pin_oe,
  output logic              serial_out_pin,
  output logic              serial_out_pin_oe,
  input  wire logic         serial_in_pin
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ssfe_pkg::ssfe_state_t st;
    logic [7:0]            div;
    logic [6:0]            h;
    logic                  sclk;
    logic                  fss;
    logic                  sout;
    logic                  oe;
    logic [15:0]           tx_sh;
    logic [15:0]           rx_sh;
    logic [15:0]           rx_word;
    logic                  rx_pulse;
    logic [6:0]            sedge;
    logic                  ck_s1;
    logic                  ck_s2;
    logic                  ck_s3;
    logic                  fs_s1;
    logic                  fs_s2;
    logic                  fs_s3;
    logic                  di_s1;
    logic                  di_s2;
  } ssfe_core_t;

  ssfe_core_t    s_reg;
  ssfe_core_t    s_next;
  logic [15:0]   q_data;
  logic          q_valid;
  logic          q_pop;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  ssfe_fifo #(
    .W     (16),
    .DEPTH (ssfe_pkg::FIFO_DEPTH)
  ) u_txq (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_pop)
  );

  function automatic logic [15:0] ssfe_align(input logic [15:0] w, input logic cmd, input logic [3:0] nm1);
    logic [15:0] r;
    r = cmd ? {w[7:0], ssfe_pkg::BYTE_ZERO} : (w << (4'd15 - nm1));
    return r;
  endfunction : ssfe_align

  logic        cmd;
  logic        ph;
  logic        pol;
  logic [6:0]  n2;
  logic [6:0]  c2;
  logic [6:0]  e;
  logic        tick;
  logic [6:0]  se;
  logic        s_edge;
  logic        fs_fall;

  always_comb begin
    cmd     = frame_format == ssfe_pkg::FMT_CMD;
    // The command format clocks like polarity 0, phase 0: sample rising, change falling.
    ph      = cmd ? 1'b0 : clock_phase_select;
    pol     = cmd ? 1'b0 : clock_idle_polarity;
    n2      = {2'b00, data_bits_m1, 1'b0} + 7'd2;
    c2      = {2'b00, reply_bits_m1, 1'b0} + 7'd2 + ((ssfe_pkg::CMD_BITS + ssfe_pkg::CMD_WAIT) << 1);
    e       = s_reg.h + ((cmd || ph) ? 7'd1 : 7'd0);
    tick    = s_reg.div == 8'(HALF - 1);
    se      = s_reg.sedge + 7'd1;
    s_edge  = s_reg.ck_s2 != s_reg.ck_s3;
    fs_fall = s_reg.fs_s3 & ~s_reg.fs_s2;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    q_pop           = 1'b0;
    s_next.rx_pulse = 1'b0;
    // Pin inputs cross into core_clk through two flops before use.
    s_next.ck_s1 = serial_clock_pin_in;
    s_next.ck_s2 = s_reg.ck_s1;
    s_next.ck_s3 = s_reg.ck_s2;
    s_next.fs_s1 = frame_select_pin_in;
    s_next.fs_s2 = s_reg.fs_s1;
    s_next.fs_s3 = s_reg.fs_s2;
    s_next.di_s1 = serial_in_pin;
    s_next.di_s2 = s_reg.di_s1;

    if (!enable || !is_master) begin
      s_next.st   = ssfe_pkg::SSFE_IDLE;
      s_next.fss  = 1'b1;
      s_next.sclk = pol;
      s_next.div  = 8'h00;
      s_next.sout = 1'b0;
      s_next.oe   = 1'b0;
    end

    if (enable && !is_master) begin
      s_next.oe = ~s_reg.fs_s2;
      s_next.sout = s_reg.fs_s2 ? 1'b0 : s_reg.tx_sh[15];
      if (fs_fall) begin
        q_pop          = q_valid;
        s_next.tx_sh   = ssfe_align(q_valid ? q_data : ssfe_pkg::WORD_ZERO, 1'b0, data_bits_m1);
        s_next.sout    = s_next.tx_sh[15];
        s_next.sedge   = 7'd0;
        s_next.rx_sh   = ssfe_pkg::WORD_ZERO;
      end else if (!s_reg.fs_s2 && s_edge) begin
        s_next.sedge = se;
        if (se[0] != ph) begin
          s_next.rx_sh = {s_reg.rx_sh[14:0], s_reg.di_s2};
          if (se == n2 - 7'd1 + {6'd0, ph}) begin
            s_next.rx_word  = {s_reg.rx_sh[14:0], s_reg.di_s2};
            s_next.rx_pulse = 1'b1;
          end
        end else if (se != n2 && (!ph || se != 7'd1)) begin
          s_next.tx_sh = s_reg.tx_sh << 1;
          s_next.sout  = s_reg.tx_sh[14];
        end
        if (se == n2) begin
          s_next.sedge = 7'd0;
          // phase 1 slave reloads without a select pulse
          if (ph) begin
            q_pop        = q_valid;
            s_next.tx_sh = ssfe_align(q_valid ? q_data : ssfe_pkg::WORD_ZERO, 1'b0, data_bits_m1);
            s_next.sout  = s_next.tx_sh[15];
          end
        end
      end
    end

    if (enable && is_master) begin
      case (s_reg.st)
        ssfe_pkg::SSFE_IDLE: begin
          s_next.sclk = pol;
          s_next.fss  = 1'b1;
          s_next.sout = 1'b0;
          s_next.oe   = 1'b0;
          s_next.div  = 8'h00;
          s_next.h    = 7'd0;
          if (q_valid) begin
            q_pop         = 1'b1;
            s_next.st     = ssfe_pkg::SSFE_RUN;
            s_next.fss    = 1'b0;
            s_next.oe     = 1'b1;
            s_next.rx_sh  = ssfe_pkg::WORD_ZERO;
            s_next.tx_sh  = ssfe_align(q_data, cmd, data_bits_m1);
            s_next.sout   = cmd ? s_next.tx_sh[15] : 1'b0;
          end
        end
        ssfe_pkg::SSFE_RUN: begin
          s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
          if (tick) begin
            s_next.h = s_reg.h + 7'd1;
            if (!cmd) begin
              if (s_reg.h == 7'd0) begin
                s_next.sout = s_reg.tx_sh[15];
              end
              // phase 1 edges start with MSB
              if (e >= 7'd1 && e <= n2) begin
                s_next.sclk = ~s_reg.sclk;
                if (e[0] != ph) begin
                  s_next.rx_sh = {s_reg.rx_sh[14:0], s_reg.di_s2};
                  if (e == n2 - 7'd1 + {6'd0, ph}) begin
                    s_next.rx_word  = {s_reg.rx_sh[14:0], s_reg.di_s2};
                    s_next.rx_pulse = 1'b1;
                  end
                end else if (e != n2 && (!ph || e != 7'd1)) begin
                  s_next.tx_sh = s_reg.tx_sh << 1;
                  s_next.sout  = s_reg.tx_sh[14];
                end
              end
              if (ph && e == n2 + 7'd1 && q_valid) begin
                q_pop         = 1'b1;
                s_next.tx_sh  = ssfe_align(q_data, 1'b0, data_bits_m1);
                s_next.sout   = s_next.tx_sh[15];
                s_next.rx_sh  = ssfe_pkg::WORD_ZERO;
                s_next.sclk   = ~s_reg.sclk;
                s_next.h      = 7'd1;
              end else if (e == n2 + 7'd1 + {6'd0, ph}) begin
                // select one bit after last sample
                // phase 0 select pulse via gap
                s_next.st   = ssfe_pkg::SSFE_GAP;
                s_next.fss  = 1'b1;
                s_next.oe   = 1'b0;
                s_next.sout = 1'b0;
              end
            end else begin
              if (e <= c2) begin
                s_next.sclk = ~s_reg.sclk;
              end
              if (e[0] && e >= ssfe_pkg::CMD_FIRST_RX_EDGE && e < c2) begin
                s_next.rx_sh = {s_reg.rx_sh[14:0], s_reg.di_s2};
              end
              if (!e[0] && e < ssfe_pkg::CMD_LAST_TX_EDGE) begin
                s_next.tx_sh = s_reg.tx_sh << 1;
                s_next.sout  = s_reg.tx_sh[14];
              end else if (e == ssfe_pkg::CMD_LAST_TX_EDGE) begin
                s_next.sout = 1'b0;
              end
              if (e == c2 && q_valid) begin
                q_pop           = 1'b1;
                s_next.rx_word  = s_reg.rx_sh;
                s_next.rx_pulse = 1'b1;
                s_next.rx_sh    = ssfe_pkg::WORD_ZERO;
                s_next.tx_sh    = ssfe_align(q_data, 1'b1, data_bits_m1);
                s_next.sout     = s_next.tx_sh[15];
                s_next.h        = 7'd0;
              end else if (e == c2 + 7'd1) begin
                s_next.rx_word  = s_reg.rx_sh;
                s_next.rx_pulse = 1'b1;
                s_next.st       = ssfe_pkg::SSFE_GAP;
                s_next.fss      = 1'b1;
                s_next.oe       = 1'b0;
                s_next.sout     = 1'b0;
              end
            end
          end
        end
        ssfe_pkg::SSFE_GAP: begin
          // Select stays high at least half a bit before the next frame.
          s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
          if (tick) begin
            s_next.st = ssfe_pkg::SSFE_IDLE;
          end
        end
        default: begin
          s_next.st = ssfe_pkg::SSFE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg       <= '0;
      s_reg.fss   <= 1'b1;
      s_reg.fs_s1 <= 1'b1;
      s_reg.fs_s2 <= 1'b1;
      s_reg.fs_s3 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // pad drive per role
  assign serial_clock_pin_out = s_reg.sclk;
  assign serial_clock_pin_oe  = is_master;
  assign frame_select_pin_out = s_reg.fss;
  assign frame_select_pin_oe  = is_master;
  assign serial_out_pin       = s_reg.sout;
  assign serial_out_pin_oe    = s_reg.oe;
  assign rx_data              = s_reg.rx_word;
  assign rx_valid             = s_reg.rx_pulse;
  assign busy                 = (s_reg.st != ssfe_pkg::SSFE_IDLE) | ~s_reg.fs_s2;
endmodule : ssfe_engine

// [ssfe_properties.sv]
// Pin-level timing checks of the frame engine, bound to its top module.
`timescale 1ns/1ps
module ssfe_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic is_master,
  input wire logic frame_format,
  input wire logic clock_idle_polarity,
  input wire logic clock_phase_select,
  input wire logic rx_valid,
  input wire logic busy,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic frame_select_pin_out,
  input wire logic frame_select_pin_oe,
  input wire logic serial_out_pin,
  input wire logic serial_out_pin_oe
);
  logic [1:0] age_reg;
  wire        sck   = serial_clock_pin_out;
  wire        sel   = frame_select_pin_out;
  wire        m_spi = is_master && !frame_format;
  wire        m_cmd = is_master && frame_format;
  // Levels seen right after reset still carry the reset values, so settle first.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) age_reg <= 2'h0;
    else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_pad_role: assert property (serial_clock_pin_oe == is_master && frame_select_pin_oe == is_master)
    else $error("pad enable does not follow the role");
  a_idle_pins: assert property (is_master && !busy |-> sel && !serial_out_pin && !serial_out_pin_oe)
    else $error("idle master pins wrong");
  a_idle_clock: assert property (age_reg == 2'h3 && $past(enable, 2) && enable && m_spi && !busy |-> sck == clock_idle_polarity)
    else $error("idle clock differs from polarity");
  a_cmd_idle: assert property (age_reg == 2'h3 && $past(enable, 2) && enable && m_cmd && !busy |-> !sck)
    else $error("command idle clock not low");
  a_start_oe: assert property ($fell(sel) && is_master |-> serial_out_pin_oe)
    else $error("output driver off at frame start");
  a_first_edge: assert property ($fell(sel) && m_spi && !clock_phase_select |-> $stable(sck)[*4] ##[1:5] $changed(sck))
    else $error("phase 0 first clock edge misplaced");
  a_phase1_edge: assert property ($fell(sel) && m_spi && clock_phase_select |-> ##[0:5] ($changed(sck) && sck != clock_idle_polarity))
    else $error("phase 1 first clock edge wrong");
  a_data_edge: assert property (m_spi && !sel && $changed(serial_out_pin) && $changed(sck) |-> sck == (clock_idle_polarity ^ clock_phase_select))
    else $error("data changed on the capture edge");
  a_end_select: assert property ($rose(sel) && m_spi |-> sck == clock_idle_polarity && $past(sck, 4) == clock_idle_polarity)
    else $error("select rose too soon after last edge");
  a_cmd_start: assert property ($fell(sel) && m_cmd |-> serial_out_pin_oe && !sck)
    else $error("command frame start wrong");
  a_cmd_end: assert property ($rose(sel) && m_cmd |-> ##[0:1] rx_valid)
    else $error("reply not handed over at select rise");
endmodule : ssfe_properties
bind ssfe_engine ssfe_properties chk_u (.core_clk(core_clk), .rst_n(rst_n), .enable(enable), .is_master(is_master),
  .frame_format(frame_format), .clock_idle_polarity(clock_idle_polarity), .clock_phase_select(clock_phase_select),
  .rx_valid(rx_valid), .busy(busy), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe), .frame_select_pin_out(frame_select_pin_out),
  .frame_select_pin_oe(frame_select_pin_oe), .serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe));

// [ssfe_far_model.sv]
// Behavioural far-side serial slave: SPI in all modes and command/reply.
`timescale 1ns/1ps
module ssfe_far_model (
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic        cmd,
  input  wire logic [3:0]  nb,
  input  wire logic [15:0] word,
  output logic             miso,
  output logic [15:0]      got
);
  logic [15:0] sr;
  logic [15:0] rx;
  logic        q;
  logic        drv;
  logic        first;
  int          cnt;
  initial begin
    sr = 16'h0000;
    rx = 16'h0000;
    got = 16'h0000;
    q = 1'b0;
    drv = 1'b0;
    first = 1'b0;
    cnt = 0;
  end
  // a released line shows the inverse, so a stale bit never looks valid.
  assign miso = (sel_n || !drv) ? ~q : q;
  // word loaded at select fall, and driven there only outside command format.
  always @(negedge sel_n) begin
    sr = word;
    cnt = 0;
    first = pha;
    drv = !cmd;
    if (!cmd) q = word[nb];
  end
  always @(sclk) begin
    if (!sel_n && cmd) begin
      if (sclk) begin
        cnt++;
        if (cnt <= 8) rx = {rx[14:0], mosi};
        if (cnt == 8) got = {8'h00, rx[7:0]};
        if (cnt == 10 + nb) cnt = 0;
      end else begin
        drv = (cnt >= 9) && (cnt <= 9 + nb);
        if (drv) q = word[9 + nb - cnt];
      end
    end else if (!sel_n) begin
      if (sclk == (pol == pha)) begin
        rx = {rx[14:0], mosi};
        cnt++;
        if (cnt == nb + 1) begin
          got = rx & (16'hffff >> (15 - nb));
          sr = word;
          cnt = 0;
          first = pha;
        end
      end else if (first) first = 1'b0;
      else sr = {sr[14:0], 1'b0};
      q = sr[nb];
    end
  end
endmodule : ssfe_far_model

// [ssfe_testbench.sv]
// Self-checking bench of the frame engine in master and slave roles.
`timescale 1ns/1ps
module testbench;
  logic        core_clk, rst_n, enable, is_master, frame_format, idle_pol, phase, tx_valid, tx_ready;
  logic        b_sclk, b_sel_n, b_miso, rx_valid, busy, sck_o, sck_oe, sel_o, sel_oe, so, so_oe, far_miso;
  logic [3:0]  nb_m1;
  logic [15:0] tx_data, rx_data, rx_last, far_word, far_got;
  int          err_count, n_compared, n_rx, n_rise;
  wire         sck_w = sck_oe ? sck_o : b_sclk;
  wire         sel_w = sel_oe ? sel_o : b_sel_n;
  wire         si_w  = is_master ? far_miso : b_miso;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ssfe_engine dut_u (.core_clk(core_clk), .rst_n(rst_n), .enable(enable), .is_master(is_master),
    .frame_format(frame_format), .clock_idle_polarity(idle_pol), .clock_phase_select(phase), .data_bits_m1(nb_m1),
    .reply_bits_m1(nb_m1), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .busy(busy), .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe(sck_oe), .frame_select_pin_in(sel_w), .frame_select_pin_out(sel_o),
    .frame_select_pin_oe(sel_oe), .serial_out_pin(so), .serial_out_pin_oe(so_oe), .serial_in_pin(si_w));
  ssfe_far_model far_u (.sclk(sck_w), .sel_n(sel_w), .mosi(so), .pol(idle_pol), .pha(phase),
    .cmd(frame_format), .nb(nb_m1), .word(far_word), .miso(far_miso), .got(far_got));
  always @(negedge core_clk) if (rx_valid === 1'b1) begin
    rx_last = rx_data;
    n_rx++;
  end
  always @(posedge sel_w) n_rise++;
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic half(input int n);
    repeat (4 * n) @(negedge core_clk);
  endtask : half
  // Queues k words with the port off, then lets the master send them as one burst.
  task automatic mframe(input logic fmt, input logic p, input logic h, input logic [3:0] nb, input int k);
    logic [15:0] m;
    int          i;
    m = 16'hffff >> (15 - nb);
    @(negedge core_clk);
    enable = 1'b0;
    is_master = 1'b1;
    frame_format = fmt;
    idle_pol = p;
    phase = h;
    nb_m1 = nb;
    for (i = 0; i < k; i++) begin
      tx_data = 16'ha5c3 + 16'(i);
      tx_valid = 1'b1;
      @(negedge core_clk);
    end
    tx_valid = 1'b0;
    check({15'h0000, tx_ready}, 16'(k < 16));
    n_rx = 0;
    n_rise = 0;
    enable = 1'b1;
    for (i = 0; i < 20000 && (n_rx < k || busy !== 1'b0); i++) @(negedge core_clk);
    if (busy !== 1'b0) begin
      err_count++;
      report_and_stop;
    end
    check(rx_last, far_word & m);
    check(far_got, (16'ha5c3 + 16'(k - 1)) & (fmt ? 16'h00ff : m));
    check(16'(n_rx), 16'(k));
    check(16'(n_rise), (fmt || h) ? 16'h0001 : 16'(k));
    $display("test done fmt %0d pol %0d pha %0d bits %0d words %0d", fmt, p, h, nb + 1, k);
  endtask : mframe
  // The bench plays an SPI master at the link rate against the engine as slave.
  task automatic sframe(input logic p, input logic h);
    logic [15:0] got;
    logic [7:0]  sm;
    int          i;
    @(negedge core_clk);
    enable = 1'b0;
    is_master = 1'b0;
    frame_format = 1'b0;
    idle_pol = p;
    phase = h;
    nb_m1 = 4'h7;
    b_sclk = p;
    tx_data = h ? 16'h003a : 16'h00c5;
    tx_valid = 1'b1;
    @(negedge core_clk);
    tx_valid = 1'b0;
    half(1);
    enable = 1'b1;
    n_rx = 0;
    got = 16'h0000;
    sm = h ? 8'h62 : 8'h9d;
    b_sel_n = 1'b0;
    b_miso = sm[7];
    half(4);
    // Leading edge first; phase 0 samples on it, phase 1 launches on it.
    for (i = 0; i < 8; i++) begin
      b_sclk = ~p;
      if (h) begin
        b_miso = sm[7];
        sm = sm << 1;
      end else begin
        got = {got[14:0], so};
      end
      half(1);
      b_sclk = p;
      if (h) begin
        got = {got[14:0], so};
      end else begin
        sm = sm << 1;
        b_miso = sm[7];
      end
      half(1);
    end
    half(2);
    b_sel_n = 1'b1;
    b_miso = ~b_miso;
    half(2);
    check(got, h ? 16'h003a : 16'h00c5);
    check(rx_last & 16'h00ff, h ? 16'h0062 : 16'h009d);
    check(16'(n_rx), 16'h0001);
    $display("test done slave frame pol %0d pha %0d", p, h);
  endtask : sframe
  initial begin
    err_count = 0;
    n_compared = 0;
    n_rx = 0;
    n_rise = 0;
    rx_last = 16'h0000;
    enable = 1'b0;
    is_master = 1'b1;
    frame_format = 1'b0;
    idle_pol = 1'b0;
    phase = 1'b0;
    nb_m1 = 4'h7;
    tx_data = 16'h0000;
    tx_valid = 1'b0;
    b_sclk = 1'b0;
    b_sel_n = 1'b1;
    b_miso = 1'b0;
    far_word = 16'h5a69;
    rst_n = 1'b0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    mframe(1'b0, 1'b0, 1'b0, 4'h7, 2);
    mframe(1'b0, 1'b1, 1'b0, 4'hf, 2);
    mframe(1'b0, 1'b0, 1'b1, 4'h3, 3);
    mframe(1'b0, 1'b1, 1'b1, 4'hb, 2);
    mframe(1'b1, 1'b0, 1'b0, 4'h3, 1);
    mframe(1'b1, 1'b0, 1'b0, 4'hf, 2);
    mframe(1'b0, 1'b0, 1'b1, 4'h3, 16);
    sframe(1'b0, 1'b0);
    sframe(1'b1, 1'b1);
    report_and_stop;
  end
endmodule : testbench
